// >>> hw/scrc_pkg.sv
// Package: register map, field positions and types for the system control block
// Summary of operation
// - Control bit 5 keeps the debug clock running always; clear, only while core enabled.
// - Writing one to control bit 4 starts a reset of the whole part.
// - Wait field bit 0 clear lets the wait instruction enter wait mode; set ignores it.
// - Wait field values 10 or 11 lock the field until next reset, meaning still applied.
// - Every system reset updates the cause register to report the latest reset.
// - Power-on reset clears cause asynchronously; later updates are synchronous from source levels.
// - The cause register is one-hot even when several sources assert together.
// - Precedence: power-on/power-down/low-voltage, external, clock loss, watchdog timeout, software.
// - Power-on sets bit 0; external pin held after power-on gives bit 3 instead.
// - Bits 5 and 4 mark watchdog causes and select the watchdog reset vector.
// - Bit 6 marks software reset only when no higher source came together.
// - Bit 2 is set when the power manager forces a low-voltage reset.
// - Bit 1 captures the power manager power-down flag at reset exit.
// - Only one of power-on, power-down, low-voltage is set; they outrank all others.
// - Writes to unmapped offsets do nothing; unmapped reads return zero here.
// - The cause register sits at word index 0x0001, right after control.
package scrc_pkg;

    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W  = 16;
    localparam int unsigned ADDR_W = 12;

    // Word indices; byte address is four times the index
    localparam logic [ADDR_W-3:0] IDX_SYSTEM_CONTROL = 10'h000;
    localparam logic [ADDR_W-3:0] IDX_RESET_CAUSE    = 10'h001;

    // Control fields
    localparam int unsigned CTRL_DEBUG_CLK_BIT  = 5;
    localparam int unsigned CTRL_SOFT_RESET_BIT = 4;
    localparam int unsigned CTRL_STOP_LOCK_BIT  = 3;
    localparam int unsigned CTRL_STOP_BLOCK_BIT = 2;
    localparam int unsigned CTRL_WAIT_LOCK_BIT  = 1;
    localparam int unsigned CTRL_WAIT_BLOCK_BIT = 0;
    localparam logic [5:0]  CTRL_RESET          = 6'h00;

    // Cause fields
    localparam int unsigned CAUSE_W             = 7;
    localparam int unsigned CAUSE_POWER_ON      = 0;
    localparam int unsigned CAUSE_POWER_DOWN    = 1;
    localparam int unsigned CAUSE_LOW_VOLTAGE   = 2;
    localparam int unsigned CAUSE_EXTERNAL_PIN  = 3;
    localparam int unsigned CAUSE_REF_LOSS      = 4;
    localparam int unsigned CAUSE_WD_TIMEOUT    = 5;
    localparam int unsigned CAUSE_SOFTWARE      = 6;
    localparam logic [CAUSE_W-1:0] CAUSE_RESET  = 7'h01;

    // Length of the internally generated software reset
    localparam logic [7:0] SOFT_RESET_CYCLES = 8'h10;

    // Reset request levels, all active high
    typedef struct packed {
        logic low_voltage;
        logic external_pin;
        logic ref_clock_loss;
        logic watchdog_timeout;
        logic software;
    } scrc_src_t;

    typedef enum logic [1:0] {
        SCRC_RUN      = 2'b00,
        SCRC_IN_RESET = 2'b01
    } scrc_state_t;

endpackage : scrc_pkg

// >>> hw/scrc_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module scrc_pin_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Pins and clean levels
    input  wire logic [WIDTH-1:0] pin_in,
    output var  logic [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync2_reg;
    logic [WIDTH-1:0] sync3_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_reg  <= INIT;
            sync2_reg <= INIT;
            sync3_reg <= INIT;
        end
        else
        begin
            meta_reg  <= pin_in;
            sync2_reg <= meta_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // A bit moves only when two settled stages agree
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            level_out <= INIT;
        else
            level_out <= (sync2_reg & sync3_reg) | (level_out & (sync2_reg | sync3_reg));
    end

endmodule : scrc_pin_sync
`default_nettype wire

// >>> hw/scrc_top.sv
// System control and reset-cause block with APB register access
`timescale 1ns/100ps
`default_nettype none
module scrc_top (
    // APB clock and power-on reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [scrc_pkg::ADDR_W-1:0] paddr,
    input  wire logic [scrc_pkg::DATA_W-1:0] pwdata,
    input  wire logic [3:0]                  pstrb,
    output var  logic [scrc_pkg::DATA_W-1:0] prdata,
    output var  logic                        pready,
    output var  logic                        pslverr,
    // External reset pin, active low
    input  wire logic                        ext_reset_n,
    // Watchdog and power manager requests
    input  wire logic                        wd_timeout_rst,
    input  wire logic                        wd_ref_loss_rst,
    input  wire logic                        low_voltage_rst,
    input  wire logic                        power_down_flag,
    // Core status and low-power instructions
    input  wire logic                        core_enabled,
    input  wire logic                        wait_instr,
    input  wire logic                        stop_instr,
    // Control outputs
    output var  logic                        debug_clock_en,
    output var  logic                        system_reset,
    output var  logic                        wait_mode_enter,
    output var  logic                        stop_mode_enter,
    output var  logic                        watchdog_vector_sel
);
    import scrc_pkg::*;

    logic [5:0]         ctrl_reg;
    logic [CAUSE_W-1:0] cause_reg;
    logic [CAUSE_W-1:0] cause_next;
    logic [7:0]         soft_cnt_reg;
    logic               ext_pin_level;
    scrc_src_t          src;
    scrc_state_t        state_reg;
    logic               sys_active;
    logic               apb_write;
    logic               apb_setup;

    // Map a word address to a register select
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-3:0] idx);
        hit = (a[ADDR_W-1:2] == idx) && (a[1:0] == 2'b00);
    endfunction : hit

    // Precedence rank of a one-hot cause; larger wins
    function automatic logic [2:0] rank(input logic [CAUSE_W-1:0] c);
        if (c[CAUSE_POWER_ON] || c[CAUSE_POWER_DOWN] || c[CAUSE_LOW_VOLTAGE])
            rank = 3'd5;
        else if (c[CAUSE_EXTERNAL_PIN])
            rank = 3'd4;
        else if (c[CAUSE_REF_LOSS])
            rank = 3'd3;
        else if (c[CAUSE_WD_TIMEOUT])
            rank = 3'd2;
        else if (c[CAUSE_SOFTWARE])
            rank = 3'd1;
        else
            rank = 3'd0;
    endfunction : rank

    // One-hot pick of the highest active source
    function automatic logic [CAUSE_W-1:0] pick(input scrc_src_t s);
        logic [CAUSE_W-1:0] r;
        r = '0;
        if (s.low_voltage)
            r[CAUSE_LOW_VOLTAGE] = 1'b1;
        else if (s.external_pin)
            r[CAUSE_EXTERNAL_PIN] = 1'b1;
        else if (s.ref_clock_loss)
            r[CAUSE_REF_LOSS] = 1'b1;
        else if (s.watchdog_timeout)
            r[CAUSE_WD_TIMEOUT] = 1'b1;
        else if (s.software)
            r[CAUSE_SOFTWARE] = 1'b1;
        pick = r;
    endfunction : pick

    // Reset pin crosses into pclk
    scrc_pin_sync #(
        .WIDTH (1),
        .INIT  (1'b1)
    ) u_ext_sync (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_in    (ext_reset_n),
        .level_out (ext_pin_level)
    );

    assign src.low_voltage      = low_voltage_rst;
    assign src.external_pin     = ~ext_pin_level;
    assign src.ref_clock_loss   = wd_ref_loss_rst;
    assign src.watchdog_timeout = wd_timeout_rst;
    assign src.software         = (soft_cnt_reg != 8'h00);
    assign sys_active           = |src;

    // Zero-wait APB; write lands in the access phase
    assign apb_setup = psel & ~penable;
    assign apb_write = psel & penable & pwrite & pready;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= 1'b1;
            pslverr <= 1'b0;
        end
    end

    // Read data is registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= '0;
        else if (apb_setup && !pwrite)
        begin
            if (hit(paddr, IDX_SYSTEM_CONTROL))
                prdata <= {26'h0, ctrl_reg};
            else if (hit(paddr, IDX_RESET_CAUSE))
                prdata <= {25'h0, cause_reg};
            else
                prdata <= '0;
        end
    end

    // Control register; system reset clears fields and locks
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_reg <= CTRL_RESET;
        else if (sys_active)
            ctrl_reg <= CTRL_RESET;
        else if (apb_write && hit(paddr, IDX_SYSTEM_CONTROL) && pstrb[0])
        begin
            ctrl_reg[CTRL_DEBUG_CLK_BIT] <= pwdata[CTRL_DEBUG_CLK_BIT];
            // Bit 4 is a trigger only and never stored
            ctrl_reg[CTRL_SOFT_RESET_BIT] <= 1'b0;
            // Lock bit set means field frozen until next reset
            if (!ctrl_reg[CTRL_WAIT_LOCK_BIT])
            begin
                ctrl_reg[CTRL_WAIT_LOCK_BIT]  <= pwdata[CTRL_WAIT_LOCK_BIT];
                ctrl_reg[CTRL_WAIT_BLOCK_BIT] <= pwdata[CTRL_WAIT_BLOCK_BIT];
            end
            if (!ctrl_reg[CTRL_STOP_LOCK_BIT])
            begin
                ctrl_reg[CTRL_STOP_LOCK_BIT]  <= pwdata[CTRL_STOP_LOCK_BIT];
                ctrl_reg[CTRL_STOP_BLOCK_BIT] <= pwdata[CTRL_STOP_BLOCK_BIT];
            end
        end
    end

    // Software reset stretched to a fixed length
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            soft_cnt_reg <= 8'h00;
        else if (apb_write && hit(paddr, IDX_SYSTEM_CONTROL) && pstrb[0]
                 && pwdata[CTRL_SOFT_RESET_BIT] && !sys_active)
            soft_cnt_reg <= SOFT_RESET_CYCLES;
        else if (soft_cnt_reg != 8'h00)
            soft_cnt_reg <= soft_cnt_reg - 8'h01;
    end

    // Track reset episodes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_reg <= SCRC_IN_RESET;
        else
        begin
            case (state_reg)
                SCRC_RUN:
                    if (sys_active)
                        state_reg <= SCRC_IN_RESET;
                SCRC_IN_RESET:
                    if (!sys_active)
                        state_reg <= SCRC_RUN;
                default:
                    state_reg <= SCRC_IN_RESET;
            endcase
        end
    end

    // Cause update: new episode overwrites, later sources only upgrade
    always_comb
    begin
        cause_next = cause_reg;
        if (sys_active)
        begin
            if (state_reg == SCRC_RUN)
                cause_next = pick(src);
            else if (rank(pick(src)) > rank(cause_reg))
                cause_next = pick(src);
        end
        else if (state_reg == SCRC_IN_RESET && power_down_flag)
        begin
            // Snapshot of the power-down flag at reset exit
            cause_next = '0;
            cause_next[CAUSE_POWER_DOWN] = 1'b1;
        end
    end

    // Power-on clears the record to the power-on cause only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cause_reg <= CAUSE_RESET;
        else
            cause_reg <= cause_next;
    end

    // System reset request and low-power entry pulses
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            system_reset    <= 1'b1;
            wait_mode_enter <= 1'b0;
            stop_mode_enter <= 1'b0;
        end
        else
        begin
            system_reset    <= sys_active;
            wait_mode_enter <= wait_instr & ~ctrl_reg[CTRL_WAIT_BLOCK_BIT] & ~sys_active;
            stop_mode_enter <= stop_instr & ~ctrl_reg[CTRL_STOP_BLOCK_BIT] & ~sys_active;
        end
    end

    // Debug clock and vector choice follow live state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            debug_clock_en      <= 1'b0;
            watchdog_vector_sel <= 1'b0;
        end
        else
        begin
            debug_clock_en      <= ctrl_reg[CTRL_DEBUG_CLK_BIT] | core_enabled;
            watchdog_vector_sel <= cause_next[CAUSE_WD_TIMEOUT]
                                   | cause_next[CAUSE_REF_LOSS];
        end
    end

endmodule : scrc_top
`default_nettype wire

// >>> testbench/scrc_sva.sv
// Port checker for the system control and reset-cause block
`timescale 1ns/100ps
`default_nettype none
module scrc_sva (
    // Clock, reset and bus
    input wire logic                        pclk,
    input wire logic                        presetn,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [scrc_pkg::ADDR_W-1:0] paddr,
    input wire logic [scrc_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0]                  pstrb,
    input wire logic [scrc_pkg::DATA_W-1:0] prdata,
    input wire logic                        pready,
    input wire logic                        pslverr,
    // Sources and core
    input wire logic                        wd_timeout_rst,
    input wire logic                        wd_ref_loss_rst,
    input wire logic                        low_voltage_rst,
    input wire logic                        core_enabled,
    input wire logic                        wait_instr,
    // Outputs
    input wire logic                        debug_clock_en,
    input wire logic                        system_reset,
    input wire logic                        wait_mode_enter,
    input wire logic                        watchdog_vector_sel
);
    import scrc_pkg::*;
    wire rd = psel && penable && !pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence soft_wr;
        psel && penable && pwrite && pready && pstrb[0]
            && paddr[ADDR_W-1:2] == IDX_SYSTEM_CONTROL && pwdata[CTRL_SOFT_RESET_BIT];
    endsequence
    // Soft source lasts 16 cycles, so 8 of reset is a safe lower bound
    sequence rst_hold;
        system_reset [*8];
    endsequence
    // Sampled reset guards the edge at which reset lets go
    ready_ok_a: assert property (presetn |=> pready && !pslverr)
        else $error("bus answer missing or error flagged");
    dbg_clk_a: assert property (presetn && core_enabled |=> debug_clock_en)
        else $error("debug clock off while core enabled");
    wait_pulse_a: assert property (wait_mode_enter |-> $past(wait_instr))
        else $error("wait entry without instruction");
    src_reset_a: assert property (presetn && (low_voltage_rst || wd_ref_loss_rst || wd_timeout_rst)
        |=> system_reset)
        else $error("source did not reset the part");
    soft_reset_a: assert property (soft_wr |=> ##1 rst_hold)
        else $error("soft reset write did not reset the part");
    cause_hot_a: assert property (rd && paddr[ADDR_W-1:2] == IDX_RESET_CAUSE |->
        $onehot(prdata[CAUSE_W-1:0]) && prdata[DATA_W-1:CAUSE_W] == '0)
        else $error("cause not one-hot");
    vec_sel_a: assert property (rd && paddr[ADDR_W-1:2] == IDX_RESET_CAUSE |->
        watchdog_vector_sel == (prdata[CAUSE_REF_LOSS] || prdata[CAUSE_WD_TIMEOUT]))
        else $error("vector select disagrees with cause");
    unmap_rd_a: assert property (rd && paddr[ADDR_W-1:3] != '0 |-> prdata == '0)
        else $error("unmapped read not zero");
endmodule : scrc_sva
bind scrc_top scrc_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .wd_timeout_rst, .wd_ref_loss_rst, .low_voltage_rst,
    .core_enabled, .wait_instr, .debug_clock_en, .system_reset, .wait_mode_enter,
    .watchdog_vector_sel);
`default_nettype wire

// >>> testbench/scrc_far.sv
// Model of the watchdog, power manager and external reset pin
`timescale 1ns/100ps
`default_nettype none
module scrc_far (
    // Clock
    input  wire logic pclk,
    // Reset requests toward the block
    output var  logic ext_reset_n,
    output var  logic wd_timeout_rst,
    output var  logic wd_ref_loss_rst,
    output var  logic low_voltage_rst,
    output var  logic power_down_flag
);
    initial
    begin
        ext_reset_n = 1'b1;
        wd_timeout_rst = 1'b0;
        wd_ref_loss_rst = 1'b0;
        low_voltage_rst = 1'b0;
        power_down_flag = 1'b0;
    end
    // Mask: 0 low voltage, 1 pin, 2 ref loss, 3 timeout, 5 power-down flag
    task automatic fire(input logic [5:0] m, input int n);
        @(posedge pclk);
        low_voltage_rst <= m[0];
        ext_reset_n <= !m[1];
        wd_ref_loss_rst <= m[2];
        wd_timeout_rst <= m[3];
        power_down_flag <= m[5];
        repeat (n) @(posedge pclk);
        low_voltage_rst <= 1'b0;
        ext_reset_n <= 1'b1;
        wd_ref_loss_rst <= 1'b0;
        wd_timeout_rst <= 1'b0;
        // Flag outlives the sources by 3 cycles; the exit snapshot sees it unless the synchronised pin was among them
        repeat (3) @(posedge pclk);
        power_down_flag <= 1'b0;
    endtask : fire
endmodule : scrc_far
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench for the system control and reset-cause block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import scrc_pkg::*;
    logic              pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic              pwrite = 1'b0, core_enabled = 1'b0, wait_instr = 1'b0;
    logic              stop_instr = 1'b0, pready, pslverr, ext_reset_n, wd_timeout_rst;
    logic              wd_ref_loss_rst, low_voltage_rst, power_down_flag, debug_clock_en;
    logic              system_reset, wait_mode_enter, stop_mode_enter, watchdog_vector_sel;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0, prdata, rd;
    logic [3:0]        pstrb = 4'hf;
    logic [31:0]       seed = 32'h7469;
    int                err_count = 0, num_checks = 0, cyc = 0, m, ctrl_m = 0;
    always #2 pclk = ~pclk;
    scrc_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .ext_reset_n, .wd_timeout_rst, .wd_ref_loss_rst,
        .low_voltage_rst, .power_down_flag, .core_enabled, .wait_instr, .stop_instr,
        .debug_clock_en, .system_reset, .wait_mode_enter, .stop_mode_enter,
        .watchdog_vector_sel);
    scrc_far u_far (.pclk, .ext_reset_n, .wd_timeout_rst, .wd_ref_loss_rst,
        .low_voltage_rst, .power_down_flag);
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // Highest source wins; the power-down snapshot overrides at exit
    function automatic int exp_cause(input int v);
        if (v & 32) return 2;
        for (int b = 0; b < 5; b++)
            if (v & (1 << b)) return 4 << b;
        return 1;
    endfunction : exp_cause
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input int d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= 32'(d);
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input logic [ADDR_W-1:0] a, input int e);
        apb(1'b0, a, 0);
        chk(rd, 32'(e));
    endtask : rdc
    // Locked fields keep their value; a soft reset clears everything
    task automatic wr(input int d);
        apb(1'b1, 12'h000, d);
        ctrl_m = (d & 32) | (ctrl_m[1] ? ctrl_m & 3 : d & 3) | (ctrl_m[3] ? ctrl_m & 12 : d & 12);
        if (d & 16) ctrl_m = 0;
    endtask : wr
    task automatic wait_rst();
        int k;
        k = 0;
        repeat (2) @(posedge pclk);
        while (system_reset !== 1'b0 && k < 300)
        begin
            @(posedge pclk);
            k++;
        end
        // A reset that never ends is a failure, not a pass
        if (k >= 300)
            err_count++;
        repeat (4) @(posedge pclk);
    endtask : wait_rst
    task automatic instr();
        @(posedge pclk);
        wait_instr <= 1'b1;
        stop_instr <= 1'b1;
        @(posedge pclk);
        wait_instr <= 1'b0;
        stop_instr <= 1'b0;
        #1;
        chk(wait_mode_enter, !ctrl_m[0]);
        chk(stop_mode_enter, !ctrl_m[2]);
    endtask : instr
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rdc(12'h000, 0);
        rdc(12'h004, 1);
        apb(1'b1, 12'h004, 255);
        apb(1'b1, 12'h00c, 63);
        rdc(12'h004, 1);
        rdc(12'h00c, 0);
        $display("test registers done");
        wr(32'h23);
        rdc(12'h000, ctrl_m);
        chk(debug_clock_en, 1);
        instr();
        wr(32'h04);
        rdc(12'h000, ctrl_m);
        chk(debug_clock_en, 0);
        instr();
        $display("test control done");
        wr(32'h10);
        wait_rst();
        rdc(12'h004, exp_cause(16));
        rdc(12'h000, ctrl_m);
        instr();
        wr(32'h10);
        u_far.fire(6'h08, 3);
        wait_rst();
        rdc(12'h004, exp_cause(24));
        chk(watchdog_vector_sel, 1);
        $display("test soft reset done");
        for (int i = 0; i < 12; i++)
        begin
            m = (i < 4) ? (1 << i) : (i == 4) ? 33 : int'(xs() % 15) + 1;
            core_enabled <= m[0];
            u_far.fire(m[5:0], 10 + int'(xs() % 6));
            wait_rst();
            rdc(12'h004, exp_cause(m));
            chk(watchdog_vector_sel, (exp_cause(m) & 48) != 0);
            chk(debug_clock_en, m & 1);
        end
        $display("test sources done");
        presetn <= 1'b0;
        fork
            u_far.fire(6'h02, 20);
            begin
                repeat (3) @(posedge pclk);
                presetn <= 1'b1;
            end
        join
        wait_rst();
        rdc(12'h004, 8);
        $display("test power-on pin done");
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
